// >>> src/ahlf_pkg.sv
// Constants, types and the check-sequence step for the async link framer.
// Assumes both ends share one clock and one reset.
package ahlf_pkg;
  localparam logic [7:0] AHLF_FLAG = 8'h7E;
  localparam logic [7:0] AHLF_ESC = 8'h7D;
  localparam logic [7:0] AHLF_ESC_XOR = 8'h20;
  localparam logic [15:0] AHLF_FCS_INIT = 16'hFFFF;
  localparam logic [15:0] AHLF_FCS_POLY = 16'h8408;
  localparam logic [15:0] AHLF_FCS_GOOD = 16'hF0B8;
  // Sequence counters are 7 bits wide, modulus 128
  localparam int AHLF_SEQ_W = 7;
  // Clock cycles per line bit
  localparam int AHLF_BAUD_DIV = 16;
  localparam logic [15:0] AHLF_MIN_LEN_IS = 16'h0005;
  localparam logic [15:0] AHLF_MIN_LEN_U = 16'h0004;
  localparam logic [3:0] AHLF_CHAR_BITS = 4'hA;
  localparam logic [3:0] AHLF_STOP_IDX = 4'h9;
  localparam logic [1:0] AHLF_S_TAG = 2'h1;
  localparam logic [1:0] AHLF_U_TAG = 2'h3;

  typedef enum logic [1:0] {AHLF_I, AHLF_S, AHLF_U} ahlf_kind_type;

  // One octet step of the 16-bit check sequence, bit 0 first
  function automatic logic [15:0] ahlf_fcs_next(input logic [15:0] crc,
                                                input logic [7:0] oct);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ oct[i]) begin
        c = (c >> 1) ^ AHLF_FCS_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction
endpackage

// >>> src/ahlf_link_if.sv
// Serial start/stop line between the two ends.
// Assumes the testbench instantiates it and joins both ends.
`timescale 1ns/100ps
interface ahlf_link_if;
  logic line_bit;
  modport tx_mp (output line_bit);
  modport rx_mp (input line_bit);
endinterface

// >>> src/ahlf_tx_end.sv
// Transmitting end: builds extended-format frames and sends them
// as start/stop characters on the line.
// Assumes payload sources honour pay_ready_out.
`timescale 1ns/100ps
module ahlf_tx_end #(
  parameter int BAUD_DIV = ahlf_pkg::AHLF_BAUD_DIV
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Frame request
  input wire logic frm_start_in,
  input wire ahlf_pkg::ahlf_kind_type frm_kind_in,
  input wire logic [7:0] frm_addr_in,
  input wire logic [7:0] frm_ctl_in,
  input wire logic [ahlf_pkg::AHLF_SEQ_W-1:0] frm_nr_in,
  input wire logic frm_pf_in,
  input wire logic frm_info_in,
  input wire logic vs_clear_in,
  // Information field stream
  input wire logic pay_valid_in,
  input wire logic [7:0] pay_data_in,
  input wire logic pay_last_in,
  output logic pay_ready_out,
  // Status
  output logic busy_out,
  output logic frm_done_out,
  output logic [ahlf_pkg::AHLF_SEQ_W-1:0] vs_out,
  // Line
  ahlf_link_if.tx_mp link
);
  import ahlf_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPEN, ST_ADDR, ST_CTL1, ST_CTL2,
    ST_INFO, ST_FCS1, ST_FCS2, ST_CLOSE
  } ahlf_tx_state_type;

  ahlf_tx_state_type state_ff;
  ahlf_tx_state_type nxt_state;
  ahlf_kind_type kind_ff;
  logic [7:0] addr_ff;
  logic [7:0] ctl_ff;
  logic [AHLF_SEQ_W-1:0] nr_ff;
  logic pf_ff;
  logic info_ff;
  logic [AHLF_SEQ_W-1:0] vs_ff;
  logic [15:0] crc_ff;
  logic esc_pend_ff;
  logic [7:0] esc_oct_ff;
  logic [15:0] div_ff;
  logic [9:0] sh_ff;
  logic [3:0] left_ff;
  logic line_ff;
  logic done_ff;
  logic tick;
  logic ser_idle;
  logic emit;
  logic advance;
  logic delim;
  logic in_fcs;
  logic need_esc;
  logic [7:0] raw;
  logic [7:0] out_oct;

  // Bit rate enable
  assign tick = (div_ff == 16'(BAUD_DIV - 1));

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_ff <= 16'h0000;
    end else if (tick) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end

  // Octet chosen by the current frame part
  always_comb begin
    raw = AHLF_FLAG;
    delim = 1'b0;
    in_fcs = 1'b0;
    case (state_ff)
      ST_OPEN, ST_CLOSE: begin
        delim = 1'b1;
      end
      ST_ADDR: begin
        raw = addr_ff;
        in_fcs = 1'b1;
      end
      ST_CTL1: begin
        in_fcs = 1'b1;
        case (kind_ff)
          AHLF_I: raw = {vs_ff, 1'b0};
          AHLF_S: raw = {4'h0, ctl_ff[3:2], AHLF_S_TAG};
          default: raw = {ctl_ff[7:5], pf_ff, ctl_ff[3:2], AHLF_U_TAG};
        endcase
      end
      ST_CTL2: begin
        raw = {nr_ff, pf_ff};
        in_fcs = 1'b1;
      end
      ST_INFO: begin
        raw = pay_data_in;
        in_fcs = 1'b1;
      end
      ST_FCS1: raw = ~crc_ff[7:0];
      ST_FCS2: raw = ~crc_ff[15:8];
      default: raw = AHLF_FLAG;
    endcase
  end

  assign ser_idle = (left_ff == 4'h0);
  assign emit = ser_idle && (state_ff != ST_IDLE) &&
                (esc_pend_ff || state_ff != ST_INFO || pay_valid_in);
  assign advance = emit && !esc_pend_ff;
  assign need_esc = !delim && (raw == AHLF_FLAG || raw == AHLF_ESC);
  assign pay_ready_out = (state_ff == ST_INFO) && ser_idle && !esc_pend_ff;

  always_comb begin
    if (esc_pend_ff) begin
      out_oct = esc_oct_ff;
    end else if (need_esc) begin
      out_oct = AHLF_ESC;
    end else begin
      out_oct = raw;
    end
  end

  // Second half of an escaped pair
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      esc_pend_ff <= 1'b0;
      esc_oct_ff <= 8'h00;
    end else if (emit && esc_pend_ff) begin
      esc_pend_ff <= 1'b0;
    end else if (advance && need_esc) begin
      esc_pend_ff <= 1'b1;
      esc_oct_ff <= raw ^ AHLF_ESC_XOR;
    end
  end

  // Frame sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (frm_start_in) nxt_state = ST_OPEN;
      ST_OPEN: nxt_state = ST_ADDR;
      ST_ADDR: nxt_state = ST_CTL1;
      ST_CTL1: begin
        if (kind_ff != AHLF_U) begin
          nxt_state = ST_CTL2;
        end else if (info_ff) begin
          nxt_state = ST_INFO;
        end else begin
          nxt_state = ST_FCS1;
        end
      end
      ST_CTL2: nxt_state = (info_ff && kind_ff == AHLF_I) ? ST_INFO : ST_FCS1;
      ST_INFO: if (pay_last_in) nxt_state = ST_FCS1;
      ST_FCS1: nxt_state = ST_FCS2;
      ST_FCS2: nxt_state = ST_CLOSE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_IDLE;
    end else if (state_ff == ST_IDLE || advance) begin
      state_ff <= nxt_state;
    end
  end

  // Request capture
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      kind_ff <= AHLF_I;
      addr_ff <= 8'h00;
      ctl_ff <= 8'h00;
      nr_ff <= '0;
      pf_ff <= 1'b0;
      info_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && frm_start_in) begin
      kind_ff <= frm_kind_in;
      addr_ff <= frm_addr_in;
      ctl_ff <= frm_ctl_in;
      nr_ff <= frm_nr_in;
      pf_ff <= frm_pf_in;
      info_ff <= frm_info_in && frm_kind_in != AHLF_S;
    end
  end

  // Check sequence over address, control and information
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      crc_ff <= AHLF_FCS_INIT;
    end else if (state_ff == ST_IDLE) begin
      crc_ff <= AHLF_FCS_INIT;
    end else if (advance && in_fcs) begin
      crc_ff <= ahlf_fcs_next(crc_ff, raw);
    end
  end

  // Send state, 7 bits so it wraps at 128
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vs_ff <= '0;
    end else if (vs_clear_in) begin
      vs_ff <= '0;
    end else if (advance && state_ff == ST_CLOSE && kind_ff == AHLF_I) begin
      vs_ff <= vs_ff + AHLF_SEQ_W'(1);
    end
  end

  // Start/stop character serialiser
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sh_ff <= 10'h3FF;
      left_ff <= 4'h0;
      line_ff <= 1'b1;
    end else if (emit) begin
      sh_ff <= {1'b1, out_oct, 1'b0};
      left_ff <= AHLF_CHAR_BITS;
    end else if (tick && !ser_idle) begin
      line_ff <= sh_ff[0];
      sh_ff <= {1'b1, sh_ff[9:1]};
      left_ff <= left_ff - 4'h1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= advance && state_ff == ST_CLOSE;
    end
  end

  assign link.line_bit = line_ff;
  assign busy_out = (state_ff != ST_IDLE) || !ser_idle;
  assign frm_done_out = done_ff;
  assign vs_out = vs_ff;
endmodule

// >>> src/ahlf_rx_end.sv
// Receiving end: recovers start/stop characters, removes escapes,
// checks the frame and decodes the extended control field.
// Assumes the line idles high and shares the transmitter's bit rate.
`timescale 1ns/100ps
module ahlf_rx_end #(
  parameter int BAUD_DIV = ahlf_pkg::AHLF_BAUD_DIV
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Line
  ahlf_link_if.rx_mp link,
  // Information field stream
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  // Frame result
  output logic rx_done_out,
  output logic rx_good_out,
  output ahlf_pkg::ahlf_kind_type rx_kind_out,
  output logic [7:0] rx_addr_out,
  output logic [7:0] rx_ctl_out,
  output logic [ahlf_pkg::AHLF_SEQ_W-1:0] rx_ns_out,
  output logic [ahlf_pkg::AHLF_SEQ_W-1:0] rx_nr_out,
  output logic rx_pf_out
);
  import ahlf_pkg::*;

  logic busy_ff;
  logic [15:0] cnt_ff;
  logic [3:0] idx_ff;
  logic [7:0] sh_ff;
  logic oct_v_ff;
  logic ferr_ff;
  logic in_frame_ff;
  logic esc_ff;
  logic [15:0] len_ff;
  logic [15:0] crc_ff;
  logic [7:0] d1_ff;
  logic [7:0] d2_ff;
  logic val_ff;
  logic [7:0] dat_ff;
  logic done_ff;
  logic good_ff;
  ahlf_kind_type kind_ff;
  logic [7:0] addr_ff;
  logic [7:0] ctl_ff;
  logic [AHLF_SEQ_W-1:0] ns_ff;
  logic [AHLF_SEQ_W-1:0] nr_ff;
  logic pf_ff;
  logic [7:0] v;
  logic [15:0] k;
  logic [15:0] min_len;

  // Character receiver, sampled mid-bit
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_ff <= 1'b0;
      cnt_ff <= 16'h0000;
      idx_ff <= 4'h0;
      sh_ff <= 8'h00;
      oct_v_ff <= 1'b0;
      ferr_ff <= 1'b0;
    end else begin
      oct_v_ff <= 1'b0;
      ferr_ff <= 1'b0;
      if (!busy_ff) begin
        if (!link.line_bit) begin
          busy_ff <= 1'b1;
          cnt_ff <= 16'(BAUD_DIV / 2 - 1);
          idx_ff <= 4'h0;
        end
      end else if (cnt_ff != 16'h0000) begin
        cnt_ff <= cnt_ff - 16'h0001;
      end else begin
        cnt_ff <= 16'(BAUD_DIV - 1);
        idx_ff <= idx_ff + 4'h1;
        if (idx_ff == 4'h0 && link.line_bit) begin
          busy_ff <= 1'b0;
        end else if (idx_ff == AHLF_STOP_IDX) begin
          busy_ff <= 1'b0;
          oct_v_ff <= link.line_bit;
          ferr_ff <= !link.line_bit;
        end else if (idx_ff != 4'h0) begin
          sh_ff <= {link.line_bit, sh_ff[7:1]};
        end
      end
    end
  end

  assign v = esc_ff ? (sh_ff ^ AHLF_ESC_XOR) : sh_ff;
  assign k = len_ff - 16'h0002;
  assign min_len = (kind_ff == AHLF_U) ? AHLF_MIN_LEN_U : AHLF_MIN_LEN_IS;

  // Frame assembly
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      in_frame_ff <= 1'b0;
      esc_ff <= 1'b0;
      len_ff <= 16'h0000;
      crc_ff <= AHLF_FCS_INIT;
      d1_ff <= 8'h00;
      d2_ff <= 8'h00;
      done_ff <= 1'b0;
      good_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (ferr_ff) begin
        in_frame_ff <= 1'b0;
        done_ff <= in_frame_ff && len_ff != 16'h0000;
        good_ff <= 1'b0;
      end else if (oct_v_ff) begin
        if (sh_ff == AHLF_FLAG) begin
          // A flag closes any frame and opens the next
          done_ff <= in_frame_ff && len_ff != 16'h0000;
          good_ff <= !esc_ff && crc_ff == AHLF_FCS_GOOD &&
                     len_ff >= min_len;
          in_frame_ff <= 1'b1;
          esc_ff <= 1'b0;
          len_ff <= 16'h0000;
          crc_ff <= AHLF_FCS_INIT;
        end else if (in_frame_ff && sh_ff == AHLF_ESC && !esc_ff) begin
          esc_ff <= 1'b1;
        end else if (in_frame_ff) begin
          esc_ff <= 1'b0;
          crc_ff <= ahlf_fcs_next(crc_ff, v);
          d1_ff <= v;
          d2_ff <= d1_ff;
          len_ff <= len_ff + 16'h0001;
        end
      end
    end
  end

  // Field decode, trailing two octets held back as the check sequence
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      val_ff <= 1'b0;
      dat_ff <= 8'h00;
      kind_ff <= AHLF_I;
      addr_ff <= 8'h00;
      ctl_ff <= 8'h00;
      ns_ff <= '0;
      nr_ff <= '0;
      pf_ff <= 1'b0;
    end else begin
      val_ff <= 1'b0;
      if (oct_v_ff && in_frame_ff && !ferr_ff && sh_ff != AHLF_FLAG &&
          !(sh_ff == AHLF_ESC && !esc_ff) && len_ff >= 16'h0002) begin
        if (k == 16'h0000) begin
          addr_ff <= d2_ff;
        end else if (k == 16'h0001) begin
          ctl_ff <= d2_ff;
          ns_ff <= d2_ff[7:1];
          pf_ff <= d2_ff[4];
          if (!d2_ff[0]) begin
            kind_ff <= AHLF_I;
          end else if (d2_ff[1:0] == AHLF_S_TAG) begin
            kind_ff <= AHLF_S;
          end else begin
            kind_ff <= AHLF_U;
          end
        end else if (k == 16'h0002 && kind_ff != AHLF_U) begin
          nr_ff <= d2_ff[7:1];
          pf_ff <= d2_ff[0];
        end else begin
          val_ff <= 1'b1;
          dat_ff <= d2_ff;
        end
      end
    end
  end

  assign rx_valid_out = val_ff;
  assign rx_data_out = dat_ff;
  assign rx_done_out = done_ff;
  assign rx_good_out = good_ff;
  assign rx_kind_out = kind_ff;
  assign rx_addr_out = addr_ff;
  assign rx_ctl_out = ctl_ff;
  assign rx_ns_out = ns_ff;
  assign rx_nr_out = nr_ff;
  assign rx_pf_out = pf_ff;
endmodule

// >>> verification/ahlf_link_monitor.sv
// Concurrent checks on the serial line and both ends' status.
// Assumes the testbench instantiates it beside the link interface.
`timescale 1ns/100ps
module ahlf_link_monitor #(
  parameter int BAUD_DIV = ahlf_pkg::AHLF_BAUD_DIV
) (
  // Clock and reset
  input logic clock_in,
  input logic rst_b_in,
  // Line and tx status
  input logic line_bit,
  input logic frm_start_in,
  input logic vs_clear_in,
  input logic busy_out,
  input logic frm_done_out,
  input logic [ahlf_pkg::AHLF_SEQ_W-1:0] vs_out,
  // Rx result
  input logic rx_valid_out,
  input logic rx_done_out
);
  import ahlf_pkg::*;
  localparam int LOW_MAX = 9 * BAUD_DIV;
  localparam int DRAIN_MAX = 12 * BAUD_DIV;
  logic [15:0] low_cnt_ff;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // Run length of a low line
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      low_cnt_ff <= 16'h0000;
    end else if (line_bit) begin
      low_cnt_ff <= 16'h0000;
    end else begin
      low_cnt_ff <= low_cnt_ff + 16'h0001;
    end
  end
  sequence s_take;
    frm_start_in && !busy_out;
  endsequence
  sequence s_flag_out;
    busy_out [*8];
  endsequence
  property p_idle_high;
    !busy_out |-> line_bit;
  endproperty
  property p_take_busy;
    s_take |=> busy_out;
  endproperty
  property p_done_hold;
    frm_done_out |-> s_flag_out;
  endproperty
  property p_drain;
    frm_done_out |-> ##[1:DRAIN_MAX] !busy_out;
  endproperty
  property p_stop_len;
    low_cnt_ff <= LOW_MAX;
  endproperty
  property p_vs_step;
    $changed(vs_out) |-> vs_out == ($past(vs_out) + 7'h01) || vs_out == 7'h00;
  endproperty
  property p_vs_cause;
    $changed(vs_out) |-> frm_done_out || $past(frm_done_out)
      || $past(vs_clear_in);
  endproperty
  property p_done_pulse;
    rx_done_out |=> !rx_done_out;
  endproperty
  property p_valid_pulse;
    rx_valid_out |=> !rx_valid_out;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("line not idle high between frames");
  a_take_busy: assert property (p_take_busy)
    else $error("frame request not taken");
  a_done_hold: assert property (p_done_hold)
    else $error("busy dropped while closing flag sent");
  a_drain: assert property (p_drain)
    else $error("busy held too long after closing flag");
  a_stop_len: assert property (p_stop_len)
    else $error("line low longer than one character");
  a_vs_step: assert property (p_vs_step)
    else $error("send state stepped wrongly");
  a_vs_cause: assert property (p_vs_cause)
    else $error("send state moved without a frame");
  a_done_pulse: assert property (p_done_pulse)
    else $error("frame end not a single pulse");
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("octet strobe not a single pulse");
endmodule

// >>> verification/tb.sv
// Testbench: tx end to rx end, plus a rx end fed by a faulty line.
// Assumes the design package and link interface are compiled first.
`timescale 1ns/100ps
module tb;
  import ahlf_pkg::*;
  localparam int BD = 4;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic frm_start_in = 1'b0;
  ahlf_kind_type frm_kind_in = AHLF_I;
  logic [7:0] frm_addr_in = 8'h00;
  logic [7:0] frm_ctl_in = 8'h00;
  logic [6:0] frm_nr_in = 7'h00;
  logic frm_pf_in = 1'b0;
  logic frm_info_in = 1'b0;
  logic vs_clear_in = 1'b0;
  logic pay_valid_in = 1'b0;
  logic [7:0] pay_data_in = 8'h00;
  logic pay_last_in = 1'b0;
  logic pay_ready_out, busy_out, frm_done_out, rx_valid_out, rx_done_out;
  logic rx_good_out, rx_pf_out, b_done, b_good, a_good, g_good;
  logic [6:0] vs_out, rx_ns_out, rx_nr_out;
  logic [7:0] rx_data_out, rx_addr_out, rx_ctl_out;
  ahlf_kind_type rx_kind_out;
  int fail_count = 0;
  int comparisons = 0;
  int a_cnt = 0;
  int b_cnt = 0;
  logic [7:0] pay[$];
  logic [7:0] got[$];
  logic [7:0] fq[$];
  logic [15:0] fcs_v;
  ahlf_link_if link();
  ahlf_link_if link_b();
  always #5 clock_in = ~clock_in;
  initial link_b.line_bit = 1'b1;
  ahlf_tx_end #(.BAUD_DIV(BD)) i_ahlf_tx_end (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .frm_start_in(frm_start_in),
    .frm_kind_in(frm_kind_in), .frm_addr_in(frm_addr_in),
    .frm_ctl_in(frm_ctl_in), .frm_nr_in(frm_nr_in), .frm_pf_in(frm_pf_in),
    .frm_info_in(frm_info_in), .vs_clear_in(vs_clear_in),
    .pay_valid_in(pay_valid_in), .pay_data_in(pay_data_in),
    .pay_last_in(pay_last_in), .pay_ready_out(pay_ready_out),
    .busy_out(busy_out), .frm_done_out(frm_done_out), .vs_out(vs_out),
    .link(link.tx_mp));
  ahlf_rx_end #(.BAUD_DIV(BD)) i_ahlf_rx_end (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .link(link.rx_mp), .rx_valid_out(rx_valid_out),
    .rx_data_out(rx_data_out), .rx_done_out(rx_done_out),
    .rx_good_out(rx_good_out), .rx_kind_out(rx_kind_out),
    .rx_addr_out(rx_addr_out), .rx_ctl_out(rx_ctl_out),
    .rx_ns_out(rx_ns_out), .rx_nr_out(rx_nr_out), .rx_pf_out(rx_pf_out));
  ahlf_rx_end #(.BAUD_DIV(BD)) i_ahlf_rx_end_b (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .link(link_b.rx_mp), .rx_valid_out(),
    .rx_data_out(), .rx_done_out(b_done), .rx_good_out(b_good),
    .rx_kind_out(), .rx_addr_out(), .rx_ctl_out(), .rx_ns_out(),
    .rx_nr_out(), .rx_pf_out());
  ahlf_link_monitor #(.BAUD_DIV(BD)) i_ahlf_link_monitor (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .line_bit(link.line_bit),
    .frm_start_in(frm_start_in), .vs_clear_in(vs_clear_in),
    .busy_out(busy_out), .frm_done_out(frm_done_out), .vs_out(vs_out),
    .rx_valid_out(rx_valid_out), .rx_done_out(rx_done_out));
  // Receive side capture, off the active edge
  always @(negedge clock_in) begin
    if (rx_valid_out) got.push_back(rx_data_out);
    if (rx_done_out) begin
      a_cnt++;
      a_good = rx_good_out;
    end
    if (b_done) begin
      b_cnt++;
      g_good = b_good;
    end
  end
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Reference check sequence, complemented, bit 0 of each octet first
  function automatic logic [15:0] fcs16(logic [7:0] q[$]);
    logic [15:0] c;
    c = AHLF_FCS_INIT;
    foreach (q[i]) begin
      for (int b = 0; b < 8; b++) begin
        c = (c[0] ^ q[i][b]) ? ((c >> 1) ^ AHLF_FCS_POLY) : (c >> 1);
      end
    end
    return ~c;
  endfunction
  task automatic sniff();
    logic [9:0] ch;
    @(negedge link.line_bit);
    repeat (BD / 2) @(posedge clock_in);
    for (int i = 0; i < 10; i++) begin
      ch[i] = link.line_bit;
      repeat (BD) @(posedge clock_in);
    end
    chk("first_char", ch, {1'b1, AHLF_FLAG, 1'b0});
  endtask
  task automatic send(ahlf_kind_type k, logic [7:0] a, logic [7:0] c,
                      logic [6:0] nr, logic pf);
    int d0;
    int t;
    got.delete();
    d0 = a_cnt;
    @(posedge clock_in);
    frm_start_in <= 1'b1;
    frm_kind_in <= k;
    frm_addr_in <= a;
    frm_ctl_in <= c;
    frm_nr_in <= nr;
    frm_pf_in <= pf;
    frm_info_in <= (pay.size() > 0);
    fork
      sniff();
      begin
        @(posedge clock_in);
        frm_start_in <= 1'b0;
        foreach (pay[i]) begin
          pay_valid_in <= 1'b1;
          pay_data_in <= pay[i];
          pay_last_in <= (i == pay.size() - 1);
          @(negedge clock_in);
          while (!pay_ready_out) @(negedge clock_in);
          @(posedge clock_in);
        end
        pay_valid_in <= 1'b0;
        for (t = 0; t < 4000 && a_cnt == d0; t++) @(negedge clock_in);
        while (busy_out) @(negedge clock_in);
      end
    join
    chk("rx_done", a_cnt, d0 + 1);
    chk("good", a_good, 1'b1);
    chk("addr", rx_addr_out, a);
    chk("n_octets", got.size(), pay.size());
    foreach (pay[i]) chk("octet", got[i], pay[i]);
  endtask
  task automatic drive_b(logic [7:0] q[$], int bad_stop, logic exp_good);
    int d0;
    d0 = b_cnt;
    foreach (q[i]) begin
      for (int j = -1; j < 9; j++) begin
        @(posedge clock_in);
        link_b.line_bit <= (j < 0) ? 1'b0 : (j < 8) ? q[i][j] : i != bad_stop;
        repeat (BD - 1) @(posedge clock_in);
      end
    end
    @(posedge clock_in);
    link_b.line_bit <= 1'b1;
    for (int t = 0; t < 400 && b_cnt == d0; t++) @(negedge clock_in);
    chk("b_done", b_cnt, d0 + 1);
    chk("b_good", g_good, exp_good);
    repeat (20 * BD) @(posedge clock_in);
  endtask
  initial begin
    #1000000;
    fail_count++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clock_in);
    rst_b_in <= 1'b1;
    // I frame carrying flag and escape octets
    pay = '{AHLF_FLAG, AHLF_ESC, 8'h00, 8'hA5, 8'h5E};
    send(AHLF_I, 8'h03, 8'h00, 7'h05, 1'b1);
    chk("kind", rx_kind_out, AHLF_I);
    chk("nr", rx_nr_out, 7'h05);
    chk("pf", rx_pf_out, 1'b1);
    chk("vs", vs_out, 7'h01);
    pay.delete();
    // Send state laps past 127, address hits flag and escape
    for (int n = 1; n < 130; n++) begin
      send(AHLF_I, 8'h70 + n[7:0], 8'h00, 7'h00, 1'b0);
      chk("ns", rx_ns_out, n[6:0]);
      chk("ctl_i", rx_ctl_out, {n[6:0], 1'b0});
    end
    // Every supervisory function
    for (int s = 0; s < 4; s++) begin
      send(AHLF_S, 8'h01, {4'h0, s[1:0], 2'h0}, 7'h7F, 1'b0);
      chk("kind_s", rx_kind_out, AHLF_S);
      chk("ctl_s", rx_ctl_out, {4'h0, s[1:0], 2'h1});
      chk("nr_s", rx_nr_out, 7'h7F);
    end
    // Unnumbered with information field
    pay = '{AHLF_ESC, AHLF_FLAG};
    send(AHLF_U, 8'h01, 8'h64, 7'h00, 1'b1);
    chk("kind_u", rx_kind_out, AHLF_U);
    chk("ctl_u", rx_ctl_out, 8'h77);
    chk("pf_u", rx_pf_out, 1'b1);
    chk("vs_u", vs_out, 7'h02);
    pay.delete();
    // Send state cleared
    @(posedge clock_in);
    vs_clear_in <= 1'b1;
    @(posedge clock_in);
    vs_clear_in <= 1'b0;
    @(negedge clock_in);
    chk("vs_clr", vs_out, 7'h00);
    send(AHLF_I, 8'h01, 8'h00, 7'h00, 1'b0);
    chk("ns_clr", rx_ns_out, 7'h00);
    // Far end: extended layout with good check sequence is accepted
    fcs_v = fcs16('{8'h03, 8'h00, 8'h00});
    fq = '{AHLF_FLAG, 8'h03, 8'h00, 8'h00, fcs_v[7:0], fcs_v[15:8], AHLF_FLAG};
    drive_b(fq, -1, 1'b1);
    // Basic single-octet control with good check sequence is refused
    fcs_v = fcs16('{8'h03, 8'h00});
    fq = '{AHLF_FLAG, 8'h03, 8'h00, fcs_v[7:0], fcs_v[15:8], AHLF_FLAG};
    drive_b(fq, -1, 1'b0);
    // Faulty far end: bad check sequence, abort, bad stop bit
    drive_b('{AHLF_FLAG, 8'h03, 8'h00, 8'h12, 8'h34, AHLF_FLAG}, -1, 1'b0);
    drive_b('{AHLF_FLAG, 8'h03, AHLF_ESC, AHLF_FLAG}, -1, 1'b0);
    drive_b('{AHLF_FLAG, 8'h03, 8'h00}, 2, 1'b0);
    test_done();
  end
endmodule
